/* File: hw/lms_regs.svh */
/*
 * Register offsets, the brightness write mask, reset values and scan timing for the LED matrix scanner.
 * Assumes inclusion by bare name from design files under hw/.
 */
`ifndef LMS_REGS_SVH
`define LMS_REGS_SVH

`define LMS_CTRL_ADDR     8'hb1
`define LMS_BRIT_ADDR     8'hb2
`define LMS_CTRL_RESET    8'h04
`define LMS_BRIT_RESET    8'h44
`define LMS_BRIT_MASK     8'hf7
`define LMS_PIX_BASE      16'hf000
`define LMS_PIX_BYTES     6
`define LMS_DEAD_TICKS    3'h1
`define LMS_SLOT_TICKS    4'h8
`define LMS_PSC_DIV_MAX   7'h40

`endif

/* File: hw/lms_pkg.sv */
/*
 * Types shared by the LED matrix scanner.
 * Assumes lms_regs.svh is included by the design file that uses it.
 */
package lms_pkg;
	typedef struct packed {
		logic [1:0] duty;
		logic [1:0] psc;
		logic       hold;
		logic [2:0] brit;
	} lms_ctrl_t;

	typedef struct packed {
		logic       smdis;
		logic [2:0] brit_odd;
		logic       rsvd;
		logic [2:0] brit_even;
	} lms_brit_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lms_sfr_t;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} lms_xram_t;
endpackage : lms_pkg

/* File: hw/lms_scan.sv */
/*
 * LED matrix scanner: control registers, six-byte pixel memory and the scan engine.
 * Assumes a one-cycle special register write/read port, an external data write port,
 * and an internal RC clock tick arriving as a one-cycle enable synchronous to mclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lms_regs.svh"

module lms_scan #(
	parameter int NCOM = 4,
	parameter int NSEG = 6
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              rc_tick,
	input  wire lms_pkg::lms_sfr_t sfr,
	input  wire logic [7:0]        sfr_raddr,
	input  wire lms_pkg::lms_xram_t xram,
	output logic [7:0]             sfr_rdata,
	output logic [NCOM-1:0]        com_o,
	output logic [NCOM-1:0]        com_oe_n,
	output logic [NSEG-1:0]        seg_o,
	output logic [NSEG-1:0]        seg_oe_n,
	output logic                   scan_active
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	lms_pkg::lms_ctrl_t ctrl_q, ctrl_d;
	lms_pkg::lms_brit_t brit_q, brit_d;
	logic [7:0]         pix_q [`LMS_PIX_BYTES];
	logic [7:0]         pix_d [`LMS_PIX_BYTES];

	always_comb begin
		ctrl_d = ctrl_q;
		brit_d = brit_q;
		for (int i = 0; i < `LMS_PIX_BYTES; i++) pix_d[i] = pix_q[i];
		if (sfr.we && sfr.addr == `LMS_CTRL_ADDR) ctrl_d = sfr.wdata;
		// Bit 3 of the brightness register is not implemented and reads 0
		if (sfr.we && sfr.addr == `LMS_BRIT_ADDR) brit_d = sfr.wdata & `LMS_BRIT_MASK;
		for (int i = 0; i < `LMS_PIX_BYTES; i++) begin
			if (xram.we && xram.addr == `LMS_PIX_BASE + 16'(i)) pix_d[i] = xram.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_q <= `LMS_CTRL_RESET;
			brit_q <= `LMS_BRIT_RESET;
			for (int i = 0; i < `LMS_PIX_BYTES; i++) pix_q[i] <= 8'h00;
			sfr_rdata <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			brit_q <= brit_d;
			for (int i = 0; i < `LMS_PIX_BYTES; i++) pix_q[i] <= pix_d[i];
			sfr_rdata <= (sfr_raddr == `LMS_CTRL_ADDR) ? ctrl_q :
			             (sfr_raddr == `LMS_BRIT_ADDR) ? brit_q : 8'h00;
		end
	end

	// ----------------------------------------
	// Scan engine
	// ----------------------------------------
	// Slot 0..3: common i sinks, segments source (low nibble / byte 4).
	// Slot 4..7: common i sources, segments sink (high nibble / byte 5).
	function automatic logic [5:0] slot_pattern(input logic [2:0] slot);
		logic [1:0] c;
		logic [5:0] p;
		c = slot[1:0];
		p = '0;
		if (!slot[2]) p = {pix_q[4][2*c+1], pix_q[4][2*c], pix_q[c][3:0]};
		else          p = {pix_q[5][4+c], pix_q[5][c], pix_q[c][7:4]};
		return p;
	endfunction

	function automatic logic [2:0] level_of(input logic [2:0] slot, input int s);
		logic [2:0] l;
		l = ctrl_q.brit;
		if (!slot[2] && s >= 4) l = (s == 4) ? brit_q.brit_even : brit_q.brit_odd;
		return l;
	endfunction

	logic       run;
	logic [6:0] pre_q, pre_d;
	logic [6:0] div;
	logic       tick;
	logic [2:0] slot_q, slot_d;
	logic [3:0] sub_q, sub_d;
	logic [2:0] lvl_q [NSEG];
	logic [2:0] lvl_d [NSEG];
	logic [NSEG-1:0] segen;
	logic [NCOM-1:0] com_d, come_d;
	logic [NSEG-1:0] seg_d, sege_d;
	logic [5:0]      pat;

	assign run = ctrl_q.duty != 2'b00 && !ctrl_q.hold;
	assign div = `LMS_PSC_DIV_MAX >> ctrl_q.psc;
	// A divider shortened mid-count must not run on through its top value
	assign tick = rc_tick && (pre_q >= div - 7'h01);
	assign segen = ctrl_q.duty == 2'b01 ? 6'h0f : ctrl_q.duty == 2'b10 ? 6'h1f : 6'h3f;

	always_comb begin
		pre_d = pre_q;
		slot_d = slot_q;
		sub_d = sub_q;
		for (int s = 0; s < NSEG; s++) lvl_d[s] = lvl_q[s];
		com_d = '0;
		come_d = '1;
		seg_d = '0;
		sege_d = '1;
		pat = slot_pattern(slot_q);
		if (ctrl_q.duty == 2'b00) begin
			pre_d = '0;
			slot_d = '0;
			sub_d = '0;
		// Hold freezes the counters and floats every pin through the defaults above
		end else if (!ctrl_q.hold) begin
			if (rc_tick) pre_d = tick ? 7'h00 : pre_q + 7'h01;
			if (tick) begin
				sub_d = sub_q + 4'h1;
				if (sub_q == `LMS_SLOT_TICKS - 4'h1) begin
					sub_d = '0;
					slot_d = slot_q + 3'h1;
					for (int s = 0; s < NSEG; s++) begin
						// Smoothing steps the level by one per slot
						if (brit_q.smdis) lvl_d[s] = level_of(slot_d, s);
						else if (lvl_q[s] < level_of(slot_d, s)) lvl_d[s] = lvl_q[s] + 3'h1;
						else if (lvl_q[s] > level_of(slot_d, s)) lvl_d[s] = lvl_q[s] - 3'h1;
					end
				end
			end
			// Only the slot's common is driven; an idle common held at the opposite
			// level would light the reverse pixels of every dark segment on it
			for (int c = 0; c < NCOM; c++) come_d[c] = slot_q[1:0] != 2'(c);
			com_d = {NCOM{slot_q[2]}};
			sege_d = ~segen;
			for (int s = 0; s < NSEG; s++) begin
				// Segment at common's level is off; the pixel lights on the opposite level
				seg_d[s] = slot_q[2];
				if (sub_q >= {1'b0, `LMS_DEAD_TICKS} && pat[s] && segen[s]
				    && (sub_q - 4'h1) <= {1'b0, lvl_q[s]}) seg_d[s] = !slot_q[2];
			end
			if (sub_q < {1'b0, `LMS_DEAD_TICKS}) seg_d = {NSEG{slot_q[2]}};
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pre_q <= '0;
			slot_q <= '0;
			sub_q <= '0;
			for (int s = 0; s < NSEG; s++) lvl_q[s] <= 3'h0;
			com_o <= '0;
			com_oe_n <= '1;
			seg_o <= '0;
			seg_oe_n <= '1;
			scan_active <= 1'b0;
		end else begin
			pre_q <= pre_d;
			slot_q <= slot_d;
			sub_q <= sub_d;
			for (int s = 0; s < NSEG; s++) lvl_q[s] <= lvl_d[s];
			com_o <= com_d;
			com_oe_n <= come_d;
			seg_o <= seg_d;
			seg_oe_n <= sege_d;
			scan_active <= run;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_hold_hiz: assert property (@(posedge mclk) disable iff (reset)
		ctrl_q.hold |=> (&com_oe_n && &seg_oe_n)) else $error("hold not high impedance");
	a_off_hiz: assert property (@(posedge mclk) disable iff (reset)
		ctrl_q.duty == 2'b00 |=> &com_oe_n) else $error("off but driving");
	a_seg_count: assert property (@(posedge mclk) disable iff (reset)
		(ctrl_q.duty == 2'b01 && !ctrl_q.hold) |=> &seg_oe_n[5:4]) else $error("extra segment");
	a_run_drives: assert property (@(posedge mclk) disable iff (reset)
		run |=> ($onehot(~com_oe_n) && scan_active)) else $error("scan not driving");
	a_dead_time: assert property (@(posedge mclk) disable iff (reset)
		(run && sub_q == 4'h0) |=> seg_o == {NSEG{slot_q[2]}}) else $error("no dead time");
	a_slot_step: assert property (@(posedge mclk) disable iff (reset)
		(run && tick && sub_q == 4'h7) |=> slot_q == $past(slot_q) + 3'h1) else $error("slot");
	a_freeze: assert property (@(posedge mclk) disable iff (reset)
		(ctrl_q.hold && $past(ctrl_q.hold)) |-> $stable(slot_q)) else $error("hold moved");
	a_presc: assert property (@(posedge mclk) disable iff (reset)
		(run && rc_tick && pre_q < div - 7'h01) |=> (pre_q == $past(pre_q) + 7'h01
		&& $stable(sub_q))) else $error("prescaler");
	// Levels are checked on segments 0 and 4; the other segments share the logic
	a_dark_pixel: assert property (@(posedge mclk) disable iff (reset)
		(run && !pat[0]) |=> seg_o[0] == $past(slot_q[2])) else $error("dark pixel driven");
	a_level_direct: assert property (@(posedge mclk) disable iff (reset)
		(run && brit_q.smdis && tick && sub_q == 4'h7) |=> lvl_q[0] == $past(ctrl_q.brit))
		else $error("level not direct");
	a_group_level: assert property (@(posedge mclk) disable iff (reset)
		(run && brit_q.smdis && tick && sub_q == 4'h7 && slot_q == 3'h2)
		|=> lvl_q[4] == $past(brit_q.brit_even)) else $error("group level");
	a_smooth_step: assert property (@(posedge mclk) disable iff (reset)
		(run && !brit_q.smdis && tick && sub_q == 4'h7 && lvl_q[0] < ctrl_q.brit)
		|=> lvl_q[0] == $past(lvl_q[0]) + 3'h1) else $error("smoothing step");
	c_run: cover property (@(posedge mclk) run && slot_q == 3'h7 && tick);
	c_dead: cover property (@(posedge mclk) run && sub_q == 4'h0 && slot_q == 3'h4);
	c_hold: cover property (@(posedge mclk) ctrl_q.duty != 2'b00 && ctrl_q.hold);
	c_smooth: cover property (@(posedge mclk) !brit_q.smdis && lvl_q[0] != ctrl_q.brit);
endmodule : lms_scan
`default_nettype wire

/* File: verif/lms_led_model.sv */
/*
 * Partner model: LED matrix of anti-parallel pixel pairs on four commons and six segments.
 * Assumes active-low pin enables; an undriven pin carries no current.
 */
`timescale 1ns/1ns
`default_nettype none
module lms_led_model (
	input  wire logic [3:0]  com_o,
	input  wire logic [3:0]  com_oe_n,
	input  wire logic [5:0]  seg_o,
	input  wire logic [5:0]  seg_oe_n,
	output logic [47:0]      lit
);
	// Passive load: a pixel conducts only with both ends driven, anode high
	always_comb begin
		lit = '0;
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 6; s++) begin
				if (!com_oe_n[c] && !seg_oe_n[s] && !com_o[c] && seg_o[s])
					lit[s < 4 ? 8*c+s : 28+2*c+s] = 1'b1;
				if (!com_oe_n[c] && !seg_oe_n[s] && com_o[c] && !seg_o[s])
					lit[s < 4 ? 8*c+4+s : 24+c+4*s] = 1'b1;
			end
		end
	end
endmodule : lms_led_model
`default_nettype wire

/* File: verif/tb_led_matrix_scan_driver.sv */
/*
 * Bench for lms_scan: register reads, pixel map per duty setting, scan freeze.
 * Assumes lms_pkg, lms_scan and lms_led_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_led_matrix_scan_driver;
	logic               mclk = 0, reset = 1, rc_tick = 0, clr = 0, scan_active;
	lms_pkg::lms_sfr_t  sfr = '0;
	lms_pkg::lms_xram_t xram = '0;
	logic [7:0]         sfr_raddr = '0, sfr_rdata;
	logic [3:0]         com_o, com_oe_n;
	logic [5:0]         seg_o, seg_oe_n;
	logic [47:0]        lit, seen, pix, exp_q[$];
	logic [47:0]        vm[4] = '{48'h0, 48'h0000_ffff_ffff, 48'h0f55_ffff_ffff, {48{1'b1}}};
	logic [1:0]         kind = 0, kind_v = 0;
	int                 fail_count = 0, checks_done = 0, cyc = 0, seed = 38;
	lms_scan i_dut (.mclk(mclk), .reset(reset), .rc_tick(rc_tick), .sfr(sfr),
		.sfr_raddr(sfr_raddr), .xram(xram), .sfr_rdata(sfr_rdata), .com_o(com_o),
		.com_oe_n(com_oe_n), .seg_o(seg_o), .seg_oe_n(seg_oe_n), .scan_active(scan_active));
	lms_led_model i_led (.com_o(com_o), .com_oe_n(com_oe_n), .seg_o(seg_o),
		.seg_oe_n(seg_oe_n), .lit(lit));
	initial forever #50 mclk = ~mclk;
	// Random RC ticks make the scan rate uneven, as a free-running oscillator would
	always @(posedge mclk) begin
		rc_tick <= #1 1'($random(seed));
		kind_v <= kind;
		seen <= clr ? '0 : (seen | lit);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_mask(input logic [47:0] got, input logic [47:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t lit %h expected %h", $time, got, exp);
		end
	endtask : cmp_mask
	// Monitor: register data settles one edge after the address
	always @(negedge mclk) begin
		if (kind_v == 2'h1)
			cmp_byte(sfr_rdata, exp_q[0][7:0]);
		else if (kind_v == 2'h2)
			cmp_mask(seen, exp_q[0]);
		else if (kind_v == 2'h3)
			cmp_byte({7'h0, scan_active}, exp_q[0][7:0]);
		if (kind_v != 2'h0)
			void'(exp_q.pop_front());
	end
	task automatic wr(input bit x, input logic [15:0] a, input logic [7:0] d);
		if (x)
			xram = '{1'b1, a, d};
		else
			sfr = '{1'b1, a[7:0], d};
		@(posedge mclk) #1;
		xram.we = 1'b0;
		sfr.we = 1'b0;
		@(posedge mclk) #1;
	endtask : wr
	task automatic req(input logic [1:0] k, input logic [47:0] e, input logic [7:0] a);
		exp_q.push_back(e);
		kind = k;
		sfr_raddr = a;
		@(posedge mclk) #1;
		kind = 2'h0;
		@(posedge mclk) #1;
	endtask : req
	// Window spans more than one frame even at the slowest random tick rate
	task automatic win(input logic [47:0] e);
		clr = 1'b1;
		@(posedge mclk) #1;
		clr = 1'b0;
		repeat (1500) @(posedge mclk);
		#1 req(2'h2, e, 8'h00);
	endtask : win
	initial begin
		repeat (6) @(posedge mclk);
		#1 reset = 1'b0;
		req(2'h1, 48'h04, 8'hb1);
		req(2'h1, 48'h44, 8'hb2);
		req(2'h1, 48'h00, 8'h33);
		wr(1'b0, 16'h00b2, 8'hff);
		req(2'h1, 48'hf7, 8'hb2);
		$display("registers done");
		pix = 48'({$random(seed), $random(seed)});
		for (int k = 0; k < 6; k++)
			wr(1'b1, 16'hf000 + 16'(k), pix[8*k +: 8]);
		for (int d = 0; d < 4; d++) begin
			wr(1'b0, 16'h00b2, {d[1], 7'($random(seed))});
			wr(1'b0, 16'h00b1, {2'(d), 6'h37});
			win(pix & vm[d]);
			req(2'h3, 48'(d != 0), 8'h00);
			$display("duty %0d done", d);
		end
		wr(1'b0, 16'h00b1, 8'hff);
		win(48'h0);
		req(2'h3, 48'h0, 8'h00);
		$display("hold done");
		complete_run();
	end
endmodule : tb_led_matrix_scan_driver
`default_nettype wire
